//--- gpio_pkg.sv
// shared constants and carrier types for the port pin block
package gpio_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_PORT_B_DATA = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PORT_B_DIRECTION = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_PORT_C_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_C_DIRECTION = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_PORT_F_PULL_POLARITY = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PORT_F_PULL_ENABLE = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_PIN_MODULE_RESERVED = 8'h12;

  localparam logic [DATA_W-1:0] RST_PORT_B_DATA = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_B_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_C_DATA = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_C_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_F_PULL_POLARITY = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_F_PULL_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RESERVED_READ_VALUE = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic drive;
  } ext_byte_t;

endpackage

//--- byte_reg.sv
// one software-writable byte register with reset value
module byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [7:0] d,
  output logic [7:0] q
);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RESET_VALUE;
    end else if (we) begin
      q <= d;
    end
  end

endmodule

//--- port_pin_data_direction_pull.sv
// port b direction, port c data / upper bus byte, port f pull select
//
// Behaviour
// - external bus owning port b forces all port b pins to drive
// - that override never alters the stored port b direction bits
// - gpio pin: direction one drives output, zero is high-z input
// - emulation: port c read returns the external bus data
// - emulation: port c write updates register and goes out as bus write
// - expanded or emulation: port c bits 7..0 carry bus data 15..8, else gpio
// - otherwise port c read: register bit if output, pin level if input
// - enabled port f input pull: polarity one pull-down, zero pull-up
// - reserved register reads zero, writes change nothing
//
// Local design decision: the plain strobed port.
module port_pin_data_direction_pull (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire gpio_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic mode_expanded,
  input wire logic mode_emulation,
  input wire logic ext_owns_port_b,
  input wire gpio_pkg::ext_byte_t ext_port_b,
  input wire gpio_pkg::ext_byte_t ext_data_hi,
  input wire logic [7:0] ext_bus_rdata,
  output logic ext_wr_pulse,
  output logic [7:0] ext_wr_data,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_b,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe_b,
  input wire logic [7:0] port_f_is_input,
  output logic [7:0] port_f_pull_up,
  output logic [7:0] port_f_pull_down
);
  import gpio_pkg::*;

  logic [7:0] port_b_data;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_data;
  logic [7:0] port_c_direction;
  logic [7:0] port_f_pull_polarity;
  logic [7:0] port_f_pull_enable;
  logic [7:0] port_c_bits;
  logic [7:0] port_b_bits;
  logic [7:0] next_rdata;
  logic ext_c_active;
  logic wr_b_data;
  logic wr_b_dir;
  logic wr_c_data;
  logic wr_c_dir;
  logic wr_f_pol;
  logic wr_f_en;

  // write decode; the reserved offset has no write enable at all
  assign wr_b_data = reg_req.wr && reg_req.addr == OFS_PORT_B_DATA;
  assign wr_b_dir = reg_req.wr && reg_req.addr == OFS_PORT_B_DIRECTION;
  assign wr_c_data = reg_req.wr && reg_req.addr == OFS_PORT_C_DATA;
  assign wr_c_dir = reg_req.wr && reg_req.addr == OFS_PORT_C_DIRECTION;
  assign wr_f_pol = reg_req.wr && reg_req.addr == OFS_PORT_F_PULL_POLARITY;
  assign wr_f_en = reg_req.wr && reg_req.addr == OFS_PORT_F_PULL_ENABLE;

  // emulation also runs the external bus
  assign ext_c_active = mode_expanded || mode_emulation;

  byte_reg #(
    .RESET_VALUE(RST_PORT_B_DATA)
  ) u_port_b_data (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .we(wr_b_data),
    .d(reg_req.wdata),
    .q(port_b_data)
  );

  // only software writes reach it, never the bus override
  byte_reg #(
    .RESET_VALUE(RST_PORT_B_DIRECTION)
  ) u_port_b_direction (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .we(wr_b_dir),
    .d(reg_req.wdata),
    .q(port_b_direction)
  );

  // written in every mode, emulation included
  byte_reg #(
    .RESET_VALUE(RST_PORT_C_DATA)
  ) u_port_c_data (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .we(wr_c_data),
    .d(reg_req.wdata),
    .q(port_c_data)
  );

  byte_reg #(
    .RESET_VALUE(RST_PORT_C_DIRECTION)
  ) u_port_c_direction (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .we(wr_c_dir),
    .d(reg_req.wdata),
    .q(port_c_direction)
  );

  byte_reg #(
    .RESET_VALUE(RST_PORT_F_PULL_POLARITY)
  ) u_port_f_pull_polarity (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .we(wr_f_pol),
    .d(reg_req.wdata),
    .q(port_f_pull_polarity)
  );

  byte_reg #(
    .RESET_VALUE(RST_PORT_F_PULL_ENABLE)
  ) u_port_f_pull_enable (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .we(wr_f_en),
    .d(reg_req.wdata),
    .q(port_f_pull_enable)
  );

  // per-bit read source for the gpio view of ports b and c
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign port_c_bits[i] = port_c_direction[i] ?
                            port_c_data[i] : port_c_in[i];
    assign port_b_bits[i] = port_b_direction[i] ?
                            port_b_data[i] : port_b_in[i];
  end

  // read mux; unmapped and reserved offsets read zero
  always_comb begin
    next_rdata = RESERVED_READ_VALUE;
    unique case (reg_req.addr)
      OFS_PORT_B_DATA: begin
        next_rdata = port_b_bits;
      end
      OFS_PORT_B_DIRECTION: begin
        next_rdata = port_b_direction;
      end
      OFS_PORT_C_DATA: begin
        if (mode_emulation) begin
          next_rdata = ext_bus_rdata;
        end else begin
          next_rdata = port_c_bits;
        end
      end
      OFS_PORT_C_DIRECTION: begin
        next_rdata = port_c_direction;
      end
      OFS_PORT_F_PULL_POLARITY: begin
        next_rdata = port_f_pull_polarity;
      end
      OFS_PORT_F_PULL_ENABLE: begin
        next_rdata = port_f_pull_enable;
      end
      OFS_PIN_MODULE_RESERVED: begin
        next_rdata = RESERVED_READ_VALUE;
      end
      default: begin
        next_rdata = RESERVED_READ_VALUE;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // port c writes in emulation are mirrored onto the external bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_wr_pulse <= 1'b0;
      ext_wr_data <= 8'h00;
    end else begin
      ext_wr_pulse <= wr_c_data && mode_emulation;
      if (wr_c_data && mode_emulation) begin
        ext_wr_data <= reg_req.wdata;
      end
    end
  end

  // port b pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_b_out <= 8'h00;
      port_b_oe_b <= 8'hFF;
    end else if (ext_owns_port_b) begin
      port_b_out <= ext_port_b.data;
      port_b_oe_b <= 8'h00;
    end else begin
      port_b_out <= port_b_data;
      port_b_oe_b <= ~port_b_direction;
    end
  end

  // port c pins: upper data byte when the bus is up, gpio otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_c_out <= 8'h00;
      port_c_oe_b <= 8'hFF;
    end else if (ext_c_active) begin
      port_c_out <= ext_data_hi.data;
      port_c_oe_b <= {8{~ext_data_hi.drive}};
    end else begin
      port_c_out <= port_c_data;
      port_c_oe_b <= ~port_c_direction;
    end
  end

  // port f pull devices, only on enabled input pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_f_pull_up <= 8'h00;
      port_f_pull_down <= 8'h00;
    end else begin
      port_f_pull_down <= port_f_pull_enable & port_f_is_input &
                          port_f_pull_polarity;
      port_f_pull_up <= port_f_pull_enable & port_f_is_input &
                        ~port_f_pull_polarity;
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  property p_bus_forces_b_out;
    ext_owns_port_b |=> port_b_oe_b == 8'h00;
  endproperty
  a_bus_forces_b_out: assert property (p_bus_forces_b_out)
    else $error("port b not driven while bus owns it");

  property p_dir_kept;
    ext_owns_port_b && !wr_b_dir |=> $stable(port_b_direction);
  endproperty
  a_dir_kept: assert property (p_dir_kept)
    else $error("port b direction changed by override");

  property p_dir_restored;
    ext_owns_port_b && !wr_b_dir ##1 !ext_owns_port_b && !wr_b_dir |=>
      port_b_oe_b == ~$past(port_b_direction, 2);
  endproperty
  a_dir_restored: assert property (p_dir_restored)
    else $error("port b direction lost after override");

  property p_gpio_dir;
    !ext_owns_port_b |=> port_b_oe_b == ~$past(port_b_direction);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("port b enable does not follow direction");

  property p_emul_read;
    reg_req.rd && reg_req.addr == OFS_PORT_C_DATA && mode_emulation
      |=> reg_rdata == $past(ext_bus_rdata);
  endproperty
  a_emul_read: assert property (p_emul_read)
    else $error("emulation port c read not from bus");

  property p_emul_write;
    wr_c_data && mode_emulation |=> ext_wr_pulse &&
      ext_wr_data == $past(reg_req.wdata) &&
      port_c_data == $past(reg_req.wdata);
  endproperty
  a_emul_write: assert property (p_emul_write)
    else $error("emulation port c write not forwarded");

  property p_no_stray_write;
    !(wr_c_data && mode_emulation) |=> !ext_wr_pulse;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write)
    else $error("bus write without port c write");

  property p_expanded_pins;
    ext_c_active |=> port_c_out == $past(ext_data_hi.data) &&
      port_c_oe_b == {8{~$past(ext_data_hi.drive)}};
  endproperty
  a_expanded_pins: assert property (p_expanded_pins)
    else $error("port c does not carry bus data");

  property p_gpio_read;
    reg_req.rd && reg_req.addr == OFS_PORT_C_DATA && !mode_emulation
      |=> reg_rdata == (($past(port_c_direction) & $past(port_c_data)) |
          (~$past(port_c_direction) & $past(port_c_in)));
  endproperty
  a_gpio_read: assert property (p_gpio_read)
    else $error("port c read source wrong");

  property p_pull;
    1'b1 |=> port_f_pull_down ==
      ($past(port_f_pull_enable) & $past(port_f_is_input) &
       $past(port_f_pull_polarity)) &&
      (port_f_pull_up & port_f_pull_down) == 8'h00;
  endproperty
  a_pull: assert property (p_pull)
    else $error("port f pull selection wrong");

  property p_reserved;
    reg_req.rd && reg_req.addr == OFS_PIN_MODULE_RESERVED
      |=> reg_rdata == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved register read not zero");

  property p_cov_emul_write;
    wr_c_data && mode_emulation;
  endproperty
  c_emul_write: cover property (p_cov_emul_write);

  property p_cov_override;
    ext_owns_port_b ##1 !ext_owns_port_b;
  endproperty
  c_override: cover property (p_cov_override);

  property p_cov_gpio_read;
    wr_c_dir ##2 reg_req.rd && reg_req.addr == OFS_PORT_C_DATA;
  endproperty
  c_gpio_read: cover property (p_cov_gpio_read);

  property p_cov_pull_down;
    port_f_pull_down != 8'h00;
  endproperty
  c_pull_down: cover property (p_cov_pull_down);

endmodule

//--- port_pins_model.sv
// far-side model of the port b and port c pins
module port_pins_model (
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe_b,
  input wire logic [7:0] port_c_out,
  input wire logic [7:0] port_c_oe_b,
  input wire logic [7:0] far_b,
  input wire logic [7:0] far_c,
  output logic [7:0] port_b_in,
  output logic [7:0] port_c_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven bits show the device level, released bits the far level
  assign port_b_in = (port_b_out & ~port_b_oe_b) | (far_b & port_b_oe_b);
  assign port_c_in = (port_c_out & ~port_c_oe_b) | (far_c & port_c_oe_b);
endmodule

//--- testbench.sv
// self-checking bench for the port pin block
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end end
module testbench import gpio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  logic core_clk, rst_b, mode_expanded, mode_emulation, ext_owns_port_b;
  reg_req_t reg_req;
  ext_byte_t ext_port_b, ext_data_hi;
  logic [7:0] reg_rdata, ext_bus_rdata, ext_wr_data, far_b, far_c, d;
  logic [7:0] port_b_in, port_b_out, port_b_oe_b, port_c_in, port_c_out;
  logic [7:0] port_c_oe_b, port_f_is_input, port_f_pull_up, port_f_pull_down;
  logic ext_wr_pulse;
  int fail_count = 0;
  int checked = 0;
  row_t rows[6] = '{'{8'h03, 8'hA5, 8'hA5}, '{8'h06, 8'hF0, 8'hF0},
    '{8'h10, 8'h3C, 8'h3C}, '{8'h11, 8'hFF, 8'hFF},
    '{8'h12, 8'hFF, 8'h00}, '{8'h20, 8'h55, 8'h00}};

  port_pin_data_direction_pull port_pin_data_direction_pull_inst (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .mode_expanded(mode_expanded),
    .mode_emulation(mode_emulation), .ext_owns_port_b(ext_owns_port_b),
    .ext_port_b(ext_port_b), .ext_data_hi(ext_data_hi),
    .ext_bus_rdata(ext_bus_rdata), .ext_wr_pulse(ext_wr_pulse),
    .ext_wr_data(ext_wr_data), .port_b_in(port_b_in),
    .port_b_out(port_b_out), .port_b_oe_b(port_b_oe_b),
    .port_c_in(port_c_in), .port_c_out(port_c_out),
    .port_c_oe_b(port_c_oe_b), .port_f_is_input(port_f_is_input),
    .port_f_pull_up(port_f_pull_up), .port_f_pull_down(port_f_pull_down));

  port_pins_model port_pins_model_inst (
    .port_b_out(port_b_out), .port_b_oe_b(port_b_oe_b),
    .port_c_out(port_c_out), .port_c_oe_b(port_c_oe_b),
    .far_b(far_b), .far_c(far_c),
    .port_b_in(port_b_in), .port_c_in(port_c_in));

  always #50 core_clk = ~core_clk;

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // pin outputs follow one cycle after the cause
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    reg_req = '0;
    mode_expanded = 1'b0;
    mode_emulation = 1'b0;
    ext_owns_port_b = 1'b0;
    ext_port_b = '0;
    ext_data_hi = '0;
    ext_bus_rdata = 8'h00;
    far_b = 8'h69;
    far_c = 8'h3C;
    port_f_is_input = 8'h00;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    #1 `CHK("port_b_oe_b", 8'hFF, port_b_oe_b)
    rd(8'h03, d); `CHK("direction reset", 8'h00, d)
    rd(8'h12, d); `CHK("reserved reset", 8'h00, d)
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      `CHK("readback", rows[i].exp, d)
    end
    done("table");
    settle(); `CHK("port_b_oe_b", 8'h5A, port_b_oe_b)
    rd(8'h01, d); `CHK("port_b read", 8'h48, d)
    @(posedge core_clk);
    ext_port_b <= '{data: 8'hC3, drive: 1'b1};
    ext_owns_port_b <= 1'b1;
    settle(); `CHK("port_b_oe_b", 8'h00, port_b_oe_b)
    `CHK("port_b_out", 8'hC3, port_b_out)
    rd(8'h03, d); `CHK("direction", 8'hA5, d)
    @(posedge core_clk);
    ext_owns_port_b <= 1'b0;
    settle(); `CHK("port_b_oe_b", 8'h5A, port_b_oe_b)
    done("bus override");
    wr(8'h04, 8'hAA);
    rd(8'h04, d); `CHK("port_c read", 8'hAC, d)
    settle(); `CHK("port_c_oe_b", 8'h0F, port_c_oe_b)
    done("port c gpio");
    @(posedge core_clk);
    ext_data_hi <= '{data: 8'h5A, drive: 1'b1};
    mode_expanded <= 1'b1;
    settle(); `CHK("port_c_out", 8'h5A, port_c_out)
    `CHK("port_c_oe_b", 8'h00, port_c_oe_b)
    @(posedge core_clk);
    mode_expanded <= 1'b0;
    done("expanded");
    mode_emulation <= 1'b1;
    ext_bus_rdata <= 8'h96;
    rd(8'h04, d); `CHK("emulation read", 8'h96, d)
    wr(8'h04, 8'h33);
    #1 `CHK("ext_wr_pulse", 1'b1, ext_wr_pulse)
    `CHK("ext_wr_data", 8'h33, ext_wr_data)
    @(posedge core_clk);
    #1 `CHK("ext_wr_pulse", 1'b0, ext_wr_pulse)
    @(posedge core_clk);
    mode_emulation <= 1'b0;
    ext_data_hi <= '{data: 8'h00, drive: 1'b0};
    wr(8'h06, 8'hFF);
    rd(8'h04, d); `CHK("port_c register", 8'h33, d)
    done("emulation");
    wr(8'h10, 8'h0F);
    port_f_is_input <= 8'h3C;
    settle(); `CHK("pull_down", 8'h0C, port_f_pull_down)
    `CHK("pull_up", 8'h30, port_f_pull_up)
    done("pull select");
    // mid-run reset brings registers and pins back to idle
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1 `CHK("port_c_oe_b", 8'hFF, port_c_oe_b)
    rd(8'h11, d); `CHK("enable reset", 8'h00, d)
    rd(8'h04, d); `CHK("port_c pin read", 8'h3C, d)
    settle(); `CHK("pull_down", 8'h00, port_f_pull_down)
    done("mid-run reset");
    end_of_test();
  end
endmodule
